// ---- design/pse_seq_map.vh ----
`ifndef PSE_SEQ_MAP_VH
`define PSE_SEQ_MAP_VH

// Register byte offsets on the plain register port.
`define A_MODE 8'h00
`define A_ALLOC 8'h04
`define A_CMD 8'h08
`define A_RESULT 8'h0C
`define A_CLASS 8'h10
`define A_IRQ_STAT 8'h14
`define A_IRQ_MASK 8'h18
`define A_CTRL 8'h1C

// Per-port mode codes, two bits per port in the mode register.
`define MODE_OFF 2'h0
`define MODE_MANUAL 2'h1
`define MODE_SEMI 2'h2
`define MODE_AUTO 2'h3

// Command register fields.
`define CMD_PE_LSB 0
`define CMD_DET_LSB 8
`define CMD_CLS_LSB 16

// Interrupt status fields.
`define IRQ_FAULT_LSB 0
`define IRQ_DISC_LSB 8
`define IRQ_START_LSB 16
`define IRQ_WDT_BIT 24
`define IRQ_W 25

// Reset values.
`define MODE_RST 16'h0000
`define ALLOC_RST 16'hFFFF
`define MASK_RST 25'h0000000
`define CTRL_RST 1'h1

// Timing.
`define CLK_KHZ 25000
`define CLK_NS 40
`define FINGER_MS 100
`define FINGER_CYC (`FINGER_MS * `CLK_KHZ)
`define WDT_MS 2200
`define WDT_CYC (`WDT_MS * `CLK_KHZ)
`define SPIKE_NS 50
`define SPIKE_CYC ((`SPIKE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- design/port_sequencer.v ----
`timescale 1ns/10ps
`default_nettype none
`include "pse_seq_map.vh"

module port_sequencer #(
  parameter integer FINGER_CYC = `FINGER_CYC,
  parameter integer CW = 22
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Configuration and host commands
  input wire [1:0] mode,
  input wire [1:0] alloc,
  input wire pe_cmd,
  input wire det_cmd,
  input wire cls_cmd,
  // Measurement results, already synchronised
  input wire det_done,
  input wire det_ok,
  input wire cls_done,
  input wire cls_ok,
  input wire [1:0] cls_lvl,
  input wire fault,
  input wire mps_lost,
  // Port drive
  output reg det_en,
  output reg cls_en,
  output reg pwr_on,
  output reg vreset,
  // Results and events
  output reg det_ok_reg,
  output reg cls_ok_reg,
  output reg [1:0] cls_lvl_reg,
  output reg fault_ev,
  output reg disc_ev,
  output reg start_ev
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DET = 3'h1;
  localparam [2:0] S_CLS = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_PWR = 3'h4;

  reg [2:0] state_reg;
  reg [1:0] mode_q_reg;
  reg [CW-1:0] finger_reg;

  wire cycling = (mode == `MODE_AUTO) || (mode == `MODE_SEMI);
  wire manual = (mode == `MODE_MANUAL);
  wire finger_over = (finger_reg >= FINGER_CYC - 1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      mode_q_reg <= `MODE_OFF;
      finger_reg <= {CW{1'b0}};
      det_en <= 1'b0;
      cls_en <= 1'b0;
      pwr_on <= 1'b0;
      vreset <= 1'b0;
      det_ok_reg <= 1'b0;
      cls_ok_reg <= 1'b0;
      cls_lvl_reg <= 2'h0;
      fault_ev <= 1'b0;
      disc_ev <= 1'b0;
      start_ev <= 1'b0;
    end else begin
      vreset <= 1'b0;
      fault_ev <= 1'b0;
      disc_ev <= 1'b0;
      start_ev <= 1'b0;
      mode_q_reg <= mode;
      if (mode != mode_q_reg) begin
        // A mode change restarts this port only; power is dropped safely.
        state_reg <= S_IDLE;
        det_en <= 1'b0;
        cls_en <= 1'b0;
        pwr_on <= 1'b0;
        if (mode == `MODE_OFF) begin
          det_ok_reg <= 1'b0;
          cls_ok_reg <= 1'b0;
          cls_lvl_reg <= 2'h0;
        end
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (cycling) begin
              state_reg <= S_DET;
              det_en <= 1'b1;
            end else if (manual && pe_cmd) begin
              state_reg <= S_PWR;
              pwr_on <= 1'b1;
            end else if (manual && det_cmd) begin
              state_reg <= S_DET;
              det_en <= 1'b1;
            end else if (manual && cls_cmd) begin
              state_reg <= S_CLS;
              cls_en <= 1'b1;
              finger_reg <= {CW{1'b0}};
            end
            // Power-off mode never leaves idle.
          end
          S_DET: begin
            if (det_done) begin
              det_en <= 1'b0;
              det_ok_reg <= det_ok;
              if (cycling && det_ok) begin
                state_reg <= S_CLS;
                cls_en <= 1'b1;
                finger_reg <= {CW{1'b0}};
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_CLS: begin
            if (!finger_over) begin
              finger_reg <= finger_reg + {{(CW-1){1'b0}}, 1'b1};
            end else if (cls_done) begin
              cls_en <= 1'b0;
              cls_ok_reg <= cls_ok;
              cls_lvl_reg <= cls_lvl;
              state_reg <= S_IDLE;
              if (manual) begin
                vreset <= 1'b1;
              end else if (cls_ok && mode == `MODE_SEMI) begin
                state_reg <= S_WAIT;
              end else if (cls_ok && cls_lvl <= alloc) begin
                state_reg <= S_PWR;
                pwr_on <= 1'b1;
              end else if (cls_ok) begin
                start_ev <= 1'b1;
              end
            end
          end
          S_WAIT: begin
            if (pe_cmd) begin
              state_reg <= S_PWR;
              pwr_on <= 1'b1;
            end
          end
          S_PWR: begin
            if (fault) begin
              pwr_on <= 1'b0;
              fault_ev <= 1'b1;
              state_reg <= S_IDLE;
            end else if (mps_lost) begin
              pwr_on <= 1'b0;
              disc_ev <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // port_sequencer

`default_nettype wire

// ---- design/pse_port_mode_sequencer.v ----
// How it works
// - Auto/semi: detect forever, classify after valid detect.
// - Auto/semi: refresh results after each measurement.
// - Auto: power on after classification within allocation.
// - Semi: power only after host power-enable command.
// - Manual: no autonomous steps, single commanded measurements.
// - Manual: power-enable powers immediately, no measurement.
// - Manual: reset port voltage after last finger.
// - Off: no power, detection, classification.
// - Entering off clears port status and enables.
// - Classification opens with 100 ms finger.
// - Fault shuts port power down.
// - Lost maintain-power signature removes port power.
// - Serial-bus watchdog trips after about 2.2 s.
// - Reject spikes up to 50 ns on serial inputs.
`timescale 1ns/10ps
`default_nettype none
`include "pse_seq_map.vh"

module pse_port_mode_sequencer #(
  parameter integer PORTS = 8,
  parameter integer FINGER_CYC = `FINGER_CYC,
  parameter integer WDT_CYC = `WDT_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rd_data,
  // Serial management bus pins, watched for activity
  input wire serial_clock,
  input wire serial_data_input,
  // Measurement front end, asynchronous
  input wire [PORTS-1:0] det_done,
  input wire [PORTS-1:0] det_ok,
  input wire [PORTS-1:0] cls_done,
  input wire [PORTS-1:0] cls_ok,
  input wire [2*PORTS-1:0] cls_level,
  input wire [PORTS-1:0] fault,
  input wire [PORTS-1:0] mps_lost,
  // Port drive
  output wire [PORTS-1:0] power_en,
  output wire [PORTS-1:0] det_en,
  output wire [PORTS-1:0] cls_en,
  output wire [PORTS-1:0] port_reset,
  // Interrupt
  output reg irq
);

  localparam integer AW = 8 * PORTS;
  localparam integer SPIKE = `SPIKE_CYC;

  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the analog front end and the serial pins.

  wire [AW-1:0] ana_in = {det_done, det_ok, cls_done, cls_ok, cls_level, fault, mps_lost};
  reg [AW-1:0] ana_s1_reg;
  reg [AW-1:0] ana_s2_reg;
  reg [1:0] ser_s1_reg;
  reg [1:0] ser_s2_reg;
  reg [1:0] ser_filt_reg;
  reg [3:0] ser_cnt_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ana_s1_reg <= {AW{1'b0}};
      ana_s2_reg <= {AW{1'b0}};
      ser_s1_reg <= 2'h3;
      ser_s2_reg <= 2'h3;
    end else begin
      ana_s1_reg <= ana_in;
      ana_s2_reg <= ana_s1_reg;
      ser_s1_reg <= {serial_data_input, serial_clock};
      ser_s2_reg <= ser_s1_reg;
    end
  end

  wire [PORTS-1:0] s_det_done = ana_s2_reg[8*PORTS-1:7*PORTS];
  wire [PORTS-1:0] s_det_ok = ana_s2_reg[7*PORTS-1:6*PORTS];
  wire [PORTS-1:0] s_cls_done = ana_s2_reg[6*PORTS-1:5*PORTS];
  wire [PORTS-1:0] s_cls_ok = ana_s2_reg[5*PORTS-1:4*PORTS];
  wire [2*PORTS-1:0] s_cls_lvl = ana_s2_reg[4*PORTS-1:2*PORTS];
  wire [PORTS-1:0] s_fault = ana_s2_reg[2*PORTS-1:PORTS];
  wire [PORTS-1:0] s_mps_lost = ana_s2_reg[PORTS-1:0];

  // A new level is taken only after it has held for more samples than a
  // 50 ns spike can cover, so a glitch never reaches the activity detector.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : spike_filt
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ser_filt_reg[g] <= 1'b1;
          ser_cnt_reg[2*g+:2] <= 2'h0;
        end else if (ser_s2_reg[g] == ser_filt_reg[g]) begin
          ser_cnt_reg[2*g+:2] <= 2'h0;
        end else if (ser_cnt_reg[2*g+:2] == SPIKE[1:0]) begin
          ser_filt_reg[g] <= ser_s2_reg[g];
          ser_cnt_reg[2*g+:2] <= 2'h0;
        end else begin
          ser_cnt_reg[2*g+:2] <= ser_cnt_reg[2*g+:2] + 2'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Serial-bus watchdog.

  reg [1:0] ser_prev_reg;
  reg [31:0] wdt_cnt_reg;
  reg wdt_trip_reg;
  reg ctrl_wdt_en_reg;
  wire bus_kick = (ser_filt_reg != ser_prev_reg);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_prev_reg <= 2'h3;
      wdt_cnt_reg <= 32'h00000000;
      wdt_trip_reg <= 1'b0;
    end else begin
      ser_prev_reg <= ser_filt_reg;
      wdt_trip_reg <= 1'b0;
      if (bus_kick || !ctrl_wdt_en_reg) begin
        wdt_cnt_reg <= 32'h00000000;
      end else if (wdt_cnt_reg >= WDT_CYC - 1) begin
        wdt_cnt_reg <= 32'h00000000;
        wdt_trip_reg <= 1'b1;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host registers.

  reg [2*PORTS-1:0] mode_reg;
  reg [2*PORTS-1:0] mode_next;
  reg [2*PORTS-1:0] alloc_reg;
  reg [PORTS-1:0] pe_cmd_reg;
  reg [PORTS-1:0] det_cmd_reg;
  reg [PORTS-1:0] cls_cmd_reg;
  reg [`IRQ_W-1:0] irq_stat_reg;
  reg [`IRQ_W-1:0] irq_stat_next;
  reg [`IRQ_W-1:0] irq_mask_reg;
  reg [PORTS-1:0] off_entry;
  integer i;

  wire [PORTS-1:0] res_det;
  wire [PORTS-1:0] res_cls;
  wire [2*PORTS-1:0] res_lvl;
  wire [PORTS-1:0] ev_fault;
  wire [PORTS-1:0] ev_disc;
  wire [PORTS-1:0] ev_start;
  wire wr_cmd = wr_en && hit(addr, `A_CMD);

  always @* begin
    mode_next = mode_reg;
    if (wr_en && hit(addr, `A_MODE)) begin
      mode_next = wr_data[2*PORTS-1:0];
    end
    if (wdt_trip_reg) begin
      // A silent host can no longer supervise ports, so all are shut off.
      mode_next = {2*PORTS{1'b0}};
    end
    for (i = 0; i < PORTS; i = i + 1) begin
      off_entry[i] = (mode_reg[2*i+:2] != `MODE_OFF) && (mode_next[2*i+:2] == `MODE_OFF);
    end
    irq_stat_next = irq_stat_reg;
    if (wr_en && hit(addr, `A_IRQ_STAT)) begin
      irq_stat_next = irq_stat_next & ~wr_data[`IRQ_W-1:0];
    end
    irq_stat_next[`IRQ_FAULT_LSB+:PORTS] = irq_stat_next[`IRQ_FAULT_LSB+:PORTS] & ~off_entry;
    irq_stat_next[`IRQ_DISC_LSB+:PORTS] = irq_stat_next[`IRQ_DISC_LSB+:PORTS] & ~off_entry;
    irq_stat_next[`IRQ_START_LSB+:PORTS] = irq_stat_next[`IRQ_START_LSB+:PORTS] & ~off_entry;
    // Events are applied last so a set in the clearing cycle is kept.
    irq_stat_next[`IRQ_FAULT_LSB+:PORTS] = irq_stat_next[`IRQ_FAULT_LSB+:PORTS] | ev_fault;
    irq_stat_next[`IRQ_DISC_LSB+:PORTS] = irq_stat_next[`IRQ_DISC_LSB+:PORTS] | ev_disc;
    irq_stat_next[`IRQ_START_LSB+:PORTS] = irq_stat_next[`IRQ_START_LSB+:PORTS] | ev_start;
    irq_stat_next[`IRQ_WDT_BIT] = irq_stat_next[`IRQ_WDT_BIT] | wdt_trip_reg;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `MODE_RST;
      alloc_reg <= `ALLOC_RST;
      pe_cmd_reg <= {PORTS{1'b0}};
      det_cmd_reg <= {PORTS{1'b0}};
      cls_cmd_reg <= {PORTS{1'b0}};
      irq_stat_reg <= {`IRQ_W{1'b0}};
      irq_mask_reg <= `MASK_RST;
      ctrl_wdt_en_reg <= `CTRL_RST;
      irq <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_reg & irq_mask_reg);
      pe_cmd_reg <= wr_cmd ? wr_data[`CMD_PE_LSB+:PORTS] : {PORTS{1'b0}};
      det_cmd_reg <= wr_cmd ? wr_data[`CMD_DET_LSB+:PORTS] : {PORTS{1'b0}};
      cls_cmd_reg <= wr_cmd ? wr_data[`CMD_CLS_LSB+:PORTS] : {PORTS{1'b0}};
      if (wr_en && hit(addr, `A_ALLOC)) begin
        alloc_reg <= wr_data[2*PORTS-1:0];
      end
      if (wr_en && hit(addr, `A_IRQ_MASK)) begin
        irq_mask_reg <= wr_data[`IRQ_W-1:0];
      end
      if (wr_en && hit(addr, `A_CTRL)) begin
        ctrl_wdt_en_reg <= wr_data[0];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `A_MODE: rd_data <= {16'h0000, mode_reg};
        `A_ALLOC: rd_data <= {16'h0000, alloc_reg};
        `A_RESULT: rd_data <= {8'h00, power_en, res_cls, res_det};
        `A_CLASS: rd_data <= {16'h0000, res_lvl};
        `A_IRQ_STAT: rd_data <= {7'h00, irq_stat_reg};
        `A_IRQ_MASK: rd_data <= {7'h00, irq_mask_reg};
        `A_CTRL: rd_data <= {31'h00000000, ctrl_wdt_en_reg};
        default: rd_data <= 32'h00000000;
      endcase
    end else begin
      rd_data <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One sequencer per port.

  generate
    for (g = 0; g < PORTS; g = g + 1) begin : port
      port_sequencer #(
        .FINGER_CYC(FINGER_CYC)
      ) u_seq (
        .clk(clk),
        .rst(rst),
        .mode(mode_reg[2*g+:2]),
        .alloc(alloc_reg[2*g+:2]),
        .pe_cmd(pe_cmd_reg[g]),
        .det_cmd(det_cmd_reg[g]),
        .cls_cmd(cls_cmd_reg[g]),
        .det_done(s_det_done[g]),
        .det_ok(s_det_ok[g]),
        .cls_done(s_cls_done[g]),
        .cls_ok(s_cls_ok[g]),
        .cls_lvl(s_cls_lvl[2*g+:2]),
        .fault(s_fault[g]),
        .mps_lost(s_mps_lost[g]),
        .det_en(det_en[g]),
        .cls_en(cls_en[g]),
        .pwr_on(power_en[g]),
        .vreset(port_reset[g]),
        .det_ok_reg(res_det[g]),
        .cls_ok_reg(res_cls[g]),
        .cls_lvl_reg(res_lvl[2*g+:2]),
        .fault_ev(ev_fault[g]),
        .disc_ev(ev_disc[g]),
        .start_ev(ev_start[g])
      );
    end
  endgenerate

endmodule // pse_port_mode_sequencer

`default_nettype wire

// ---- verif/pse_port_mode_sequencer_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module pse_seq_checker #(
  parameter integer PORTS = 8,
  parameter integer FINGER_CYC = 8,
  parameter integer WDT_CYC = 50
) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Serial pins
  input wire logic serial_clock,
  input wire logic serial_data_input,
  // Front end and port drive
  input wire logic [PORTS-1:0] fault,
  input wire logic [PORTS-1:0] mps_lost,
  input wire logic [PORTS-1:0] power_en,
  input wire logic [PORTS-1:0] det_en,
  input wire logic [PORTS-1:0] cls_en,
  input wire logic [PORTS-1:0] port_reset
);
  logic [31:0] fin_cnt;
  logic [31:0] idle_cnt;
  logic [1:0] pins_n;
  logic [1:0] pins_q;

  // Pins are looked at on the falling edge, so spikes that straddle a rising edge stay unseen.
  always @(negedge clk) begin
    pins_n <= {serial_clock, serial_data_input};
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fin_cnt <= 32'h0;
      idle_cnt <= 32'h0;
      pins_q <= 2'h3;
    end else begin
      fin_cnt <= cls_en[0] ? fin_cnt + 32'h1 : 32'h0;
      idle_cnt <= (pins_n != pins_q) ? 32'h0 : idle_cnt + 32'h1;
      pins_q <= pins_n;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_read_data_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside its slot");
  a_fault_cuts_power: assert property (power_en[0] && fault[0] |-> ##[1:5] !power_en[0])
    else $error("power kept through fault");
  a_mps_cuts_power: assert property (power_en[0] && mps_lost[0] |-> ##[1:5] !power_en[0])
    else $error("power kept after disconnect");
  // A finger cut by a mode change or the watchdog is short by design, so only
  // fingers that end in power-on or a port reset are timed.
  a_finger_long: assert property ($fell(cls_en[0]) && (power_en[0] || port_reset[0]) |->
    fin_cnt >= FINGER_CYC)
    else $error("first finger too short");
  a_reset_pulse_one: assert property (port_reset[0] |=> !port_reset[0])
    else $error("port reset longer than one cycle");
  a_reset_after_finger: assert property (port_reset[0] |-> !cls_en[0] &&
    ($past(cls_en[0]) || $past(cls_en[0], 2) || $past(cls_en[0], 3)))
    else $error("port reset not after finger");
  a_power_no_measure: assert property (power_en[0] |-> !det_en[0] && !cls_en[0])
    else $error("measuring a powered port");
  a_power_has_cause: assert property ($rose(power_en[0]) |-> $past(wr_en, 2) ||
    $past(wr_en, 3) || $past(wr_en, 4) || $past(cls_en[0]) || $past(cls_en[0], 2))
    else $error("power on without cause");
  a_watchdog_off: assert property (idle_cnt > WDT_CYC + 8 |-> power_en == '0)
    else $error("power kept after bus went silent");

  cover property ($rose(power_en[0]));
  cover property (port_reset[0]);
  cover property (power_en[0] && fault[0]);
  cover property (idle_cnt > WDT_CYC + 8);
endmodule // pse_seq_checker

bind pse_port_mode_sequencer pse_seq_checker #(.PORTS(PORTS), .FINGER_CYC(FINGER_CYC),
  .WDT_CYC(WDT_CYC)) chk (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .serial_clock(serial_clock), .serial_data_input(serial_data_input),
  .fault(fault), .mps_lost(mps_lost), .power_en(power_en), .det_en(det_en),
  .cls_en(cls_en), .port_reset(port_reset));

`default_nettype wire

// ---- verif/serial_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
  // Clock and activity control
  input wire logic clk,
  input wire logic kick_on,
  // Serial pins
  output wire logic serial_clock,
  output wire logic serial_data_input
);
  logic [2:0] div = 3'h0;
  logic scl_q = 1'b1;
  logic spike = 1'b0;

  // Each level is held eight cycles so a real transition always clears the filter.
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (kick_on && div == 3'h7) begin
      scl_q <= ~scl_q;
    end
  end

  // A silent host still leaves a 30 ns noise pulse on both lines every eighth cycle.
  // Each pulse straddles one rising edge, so only a working filter keeps it out.
  always @(negedge clk) begin
    if (!kick_on && div == 3'h3) begin
      #5 spike = 1'b1;
      #30 spike = 1'b0;
    end
  end

  assign serial_clock = scl_q ^ spike;
  assign serial_data_input = ~scl_q ^ spike;
endmodule // serial_host_model

`default_nettype wire

// ---- verif/pse_port_mode_sequencer_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pse_seq_map.vh"

module pse_port_mode_sequencer_test;
  logic clk, rst, wr_en, rd_en, kick_on, irq, scl, sda;
  logic [7:0] addr, det_done, det_ok, cls_done, cls_ok, fault, mps_lost, ok_cfg;
  logic [7:0] power_en, det_en, cls_en, port_reset;
  logic [15:0] cls_level, lvl_cfg;
  logic [31:0] wr_data, rd_data;
  int error_cnt, cmp_count, cyc, n;

  pse_port_mode_sequencer #(.FINGER_CYC(8), .WDT_CYC(50)) dut (.clk(clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .serial_clock(scl), .serial_data_input(sda), .det_done(det_done), .det_ok(det_ok),
    .cls_done(cls_done), .cls_ok(cls_ok), .cls_level(cls_level), .fault(fault),
    .mps_lost(mps_lost), .power_en(power_en), .det_en(det_en), .cls_en(cls_en),
    .port_reset(port_reset), .irq(irq));

  serial_host_model host (.clk(clk), .kick_on(kick_on), .serial_clock(scl),
    .serial_data_input(sda));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The front end answers each measurement one cycle after it starts.
  always @(posedge clk) begin
    det_done <= det_en;
    det_ok <= ok_cfg;
    cls_done <= cls_en;
    cls_ok <= 8'hFF;
    cls_level <= lvl_cfg;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(rd_data & m, exp);
  endtask

  task automatic run(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wr_data = 32'h0;
    kick_on = 1'b1; ok_cfg = 8'hFF; lvl_cfg = 16'h5555; fault = 8'h00; mps_lost = 8'h00;
    det_done = 8'h00; det_ok = 8'h00; cls_done = 8'h00; cls_ok = 8'h00; cls_level = 16'h0;
    error_cnt = 0; cmp_count = 0; cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`A_MODE, 32'hFFFFFFFF, 32'h0);
    rd(`A_ALLOC, 32'hFFFFFFFF, 32'hFFFF);
    rd(`A_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rd(`A_CTRL, 32'hFFFFFFFF, 32'h1);
    rd(`A_CMD, 32'hFFFFFFFF, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    rd(`A_RESULT, 32'hFFFFFFFF, 32'h0);
    wr(`A_MODE, 32'hFFFF);
    run(60);
    check(power_en, 8'hFF);
    rd(`A_RESULT, 32'hFFFFFFFF, 32'hFFFFFF);
    rd(`A_CLASS, 32'hFFFFFFFF, 32'h5555);
    @(posedge clk) fault <= 8'h01;
    run(6);
    check(power_en, 8'hFE);
    @(posedge clk) fault <= 8'h00;
    rd(`A_IRQ_STAT, 32'h1, 32'h1);
    check(irq, 1'b0);
    wr(`A_IRQ_MASK, 32'h1);
    run(2);
    check(irq, 1'b1);
    wr(`A_IRQ_STAT, 32'h1);
    run(2);
    check(irq, 1'b0);
    run(40);
    check(power_en[0], 1'b1);
    @(posedge clk) mps_lost <= 8'h01;
    run(6);
    check(power_en[0], 1'b0);
    @(posedge clk) mps_lost <= 8'h00;
    rd(`A_IRQ_STAT, 32'h100, 32'h100);
    wr(`A_ALLOC, 32'hFFCF);
    wr(`A_MODE, 32'hFFCC);
    run(2);
    check(power_en, 8'hFA);
    rd(`A_IRQ_STAT, 32'h100, 32'h0);
    rd(`A_RESULT, 32'h050505, 32'h0);
    wr(`A_MODE, 32'hFFFF);
    run(60);
    check(power_en[2], 1'b0);
    rd(`A_IRQ_STAT, 32'h40000, 32'h40000);
    wr(`A_MODE, 32'hAAAA);
    run(60);
    check(power_en, 8'h00);
    rd(`A_RESULT, 32'hFFFF, 32'hFFFF);
    wr(`A_CMD, 32'h1);
    run(3);
    check(power_en, 8'h01);
    wr(`A_MODE, 32'h5555);
    run(20);
    check({power_en, det_en, cls_en}, 24'h0);
    wr(`A_CMD, 32'h1);
    run(3);
    check({power_en, det_en, cls_en}, 24'h010000);
    wr(`A_MODE, 32'h5554);
    run(2);
    check(power_en, 8'h00);
    wr(`A_MODE, 32'h5555);
    wr(`A_CMD, 32'h10000);
    n = 0;
    while (port_reset[0] !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(port_reset[0], 1'b1);
    run(4);
    check(cls_en, 8'h00);
    wr(`A_CMD, 32'h100);
    run(12);
    check(det_en, 8'h00);
    rd(`A_RESULT, 32'h1, 32'h1);
    @(posedge clk) ok_cfg <= 8'hFE;
    wr(`A_MODE, 32'hFFFF);
    run(40);
    check(power_en, 8'hFA);
    check(cls_en[0], 1'b0);
    rd(`A_RESULT, 32'h010001, 32'h0);
    @(posedge clk) kick_on <= 1'b0;
    run(90);
    check(power_en, 8'h00);
    rd(`A_IRQ_STAT, 32'h1000000, 32'h1000000);
    rd(`A_MODE, 32'hFFFF, 32'h0);
    wrap_up();
  end
endmodule // pse_port_mode_sequencer_test

`default_nettype wire
